// [verilog/gtrc_timer.v]
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`include "gtrc_regs.vh"

module gtrc_timer #(
    parameter PRESCALE = `GTRC_PRESCALE,
    parameter CNT_W    = 16
) (
    // clock and reset
    input  wire        MCLK,
    input  wire        SYS_RST,
    // ahb-lite slave
    input  wire        HSEL,
    input  wire [7:0]  HADDR,
    input  wire [1:0]  HTRANS,
    input  wire        HWRITE,
    input  wire [2:0]  HSIZE,
    input  wire [31:0] HWDATA,
    input  wire        HREADY,
    output reg  [31:0] HRDATA,
    output reg         HREADYOUT,
    output reg         HRESP,
    // external trigger
    input  wire        EXT_TRIGGER_PIN,
    // timer event request
    output reg         TIMER_IRQ
);

    // =================================================================
    // state
    reg  [`GTRC_CTRL_W-1:0] ctrl_reg;
    reg  [CNT_W-1:0]        timer_count_value_reg;
    reg  [CNT_W-1:0]        timer_count_value_next;
    reg  [CNT_W-1:0]        reload_capture_reg;
    reg  [CNT_W-1:0]        reload_capture_next;
    reg                     flag_reg;
    reg  [3:0]              pre_reg;
    reg                     wr_pend_reg;
    reg  [7:0]              wr_addr_reg;

    wire pin_level;
    wire pin_rise;
    wire pin_fall;

    // =================================================================
    // trigger pin conditioning
    gtrc_pin_sync u_sync (
        .MCLK    (MCLK),
        .SYS_RST (SYS_RST),
        .pin_in  (EXT_TRIGGER_PIN),
        .level   (pin_level),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    // =================================================================
    // control decode
    wire run_en   = ctrl_reg[`GTRC_CTRL_RUN];
    wire cap_mode = ctrl_reg[`GTRC_CTRL_CAPMODE];
    wire updown   = ctrl_reg[`GTRC_CTRL_UPDOWN] & ~cap_mode;
    wire ext_en   = ctrl_reg[`GTRC_CTRL_EXTEN];
    wire edge_pos = ctrl_reg[`GTRC_CTRL_EDGE];
    wire no_pre   = ctrl_reg[`GTRC_CTRL_NOPRE];

    // selected edge of the trigger pin
    wire sel_edge = edge_pos ? pin_rise : pin_fall;
    // down count only in up/down mode with pin low
    wire count_down = updown & ~pin_level;

    // =================================================================
    // prescaler: a tick every PRESCALE clocks, or every clock if bypassed
    wire pre_last = (pre_reg == PRESCALE[3:0] - 4'h1);
    wire tick     = run_en & (no_pre | pre_last);

    // prescaler only counts while running, so a start is aligned
    always @(posedge MCLK) begin
        if (SYS_RST) begin
            pre_reg <= 4'h0;
        end else if (!run_en || no_pre || pre_last) begin
            pre_reg <= 4'h0;
        end else begin
            pre_reg <= pre_reg + 4'h1;
        end
    end

    // =================================================================
    // counting, reload and capture events
    wire at_top    = (timer_count_value_reg == `GTRC_CNT_ONES);
    wire at_bottom = (timer_count_value_reg == reload_capture_reg);
    wire ovf       = tick & ~count_down & at_top;
    wire unf       = tick & count_down & at_bottom;
    wire ext_rel   = ~cap_mode & ~updown & ext_en & sel_edge;
    wire capture   = cap_mode & sel_edge;
    // events that raise the request
    wire irq_evt   = cap_mode ? (ovf | capture)
                   : (~updown & (ovf | ext_rel));

    wire        bus_wr_rc;
    wire [15:0] bus_wdata = HWDATA[15:0];

    // next count value; pin reload takes priority over a tick
    always @* begin
        timer_count_value_next = timer_count_value_reg;
        if (ext_rel) begin
            timer_count_value_next = reload_capture_reg;
        end else if (ovf) begin
            if (cap_mode) begin
                timer_count_value_next = `GTRC_CNT_ZERO;
            end else begin
                timer_count_value_next = reload_capture_reg;
            end
        end else if (unf) begin
            timer_count_value_next = `GTRC_CNT_ONES;
        end else if (tick) begin
            if (count_down) begin
                timer_count_value_next = timer_count_value_reg - 16'h0001;
            end else begin
                timer_count_value_next = timer_count_value_reg + 16'h0001;
            end
        end
    end

    // capture beats a software write landing in the same cycle
    always @* begin
        reload_capture_next = reload_capture_reg;
        if (capture) begin
            reload_capture_next = timer_count_value_reg;
        end else if (bus_wr_rc) begin
            reload_capture_next = bus_wdata;
        end
    end

    // =================================================================
    // ahb-lite slave: zero wait states, always OKAY
    wire bus_take = HSEL & HREADY & HTRANS[1];
    wire wr_ctrl  = wr_pend_reg & (wr_addr_reg == `GTRC_ADDR_CTRL);
    wire wr_stat  = wr_pend_reg & (wr_addr_reg == `GTRC_ADDR_STATUS);
    wire wr_cnt   = wr_pend_reg & (wr_addr_reg == `GTRC_ADDR_COUNT);
    assign bus_wr_rc = wr_pend_reg & (wr_addr_reg == `GTRC_ADDR_RELOAD);

    // read mux, used at the address phase so data stands in data phase
    function [31:0] rd_mux;
        input [7:0] addr;
        begin
            case (addr)
                `GTRC_ADDR_CTRL:   rd_mux = {26'h0, ctrl_reg};
                `GTRC_ADDR_STATUS: rd_mux = {29'h0, pin_level,
                                            count_down, flag_reg};
                `GTRC_ADDR_RELOAD: rd_mux = {16'h0, reload_capture_reg};
                `GTRC_ADDR_COUNT:  rd_mux = {16'h0, timer_count_value_reg};
                default:           rd_mux = 32'h0;
            endcase
        end
    endfunction

    // bus side registers
    always @(posedge MCLK) begin
        if (SYS_RST) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            HRDATA      <= 32'h0;
            HREADYOUT   <= 1'b1;
            HRESP       <= 1'b0;
            ctrl_reg    <= `GTRC_CTRL_RST;
        end else begin
            wr_pend_reg <= bus_take & HWRITE;
            wr_addr_reg <= HADDR;
            HREADYOUT   <= 1'b1;
            HRESP       <= 1'b0;
            if (bus_take & ~HWRITE) begin
                HRDATA <= rd_mux(HADDR);
            end
            if (wr_ctrl) begin
                ctrl_reg <= HWDATA[`GTRC_CTRL_W-1:0];
            end
        end
    end

    // =================================================================
    // counter, register and request flag
    always @(posedge MCLK) begin
        if (SYS_RST) begin
            timer_count_value_reg <= `GTRC_CNT_ZERO;
            reload_capture_reg    <= `GTRC_CNT_ZERO;
            flag_reg              <= 1'b0;
            TIMER_IRQ             <= 1'b0;
        end else begin
            reload_capture_reg <= reload_capture_next;
            if (wr_cnt) begin
                timer_count_value_reg <= bus_wdata;
            end else begin
                timer_count_value_reg <= timer_count_value_next;
            end
            // write one to clear; a new event wins over the clear
            if (irq_evt) begin
                flag_reg <= 1'b1;
            end else if (wr_stat & HWDATA[`GTRC_STAT_FLAG]) begin
                flag_reg <= 1'b0;
            end
            TIMER_IRQ <= irq_evt | (flag_reg &
                         ~(wr_stat & HWDATA[`GTRC_STAT_FLAG]));
        end
    end

endmodule // gtrc_timer

// [verilog/gtrc_regs.vh]
`ifndef GTRC_REGS_VH
`define GTRC_REGS_VH

// =====================================================================
// register byte addresses
`define GTRC_ADDR_CTRL      8'h00
`define GTRC_ADDR_STATUS    8'h04
`define GTRC_ADDR_RELOAD    8'h08
`define GTRC_ADDR_COUNT     8'h0C

// =====================================================================
// control register field positions
`define GTRC_CTRL_RUN       0
`define GTRC_CTRL_CAPMODE   1
`define GTRC_CTRL_UPDOWN    2
`define GTRC_CTRL_EXTEN     3
`define GTRC_CTRL_EDGE      4
`define GTRC_CTRL_NOPRE     5
`define GTRC_CTRL_W         6

// =====================================================================
// status register field positions
`define GTRC_STAT_FLAG      0
`define GTRC_STAT_DIR       1
`define GTRC_STAT_PIN       2

// =====================================================================
// reset values, counts and bus encodings
`define GTRC_CTRL_RST       6'h00
`define GTRC_CNT_ZERO       16'h0000
`define GTRC_CNT_ONES       16'hFFFF
`define GTRC_PRESCALE       12
`define GTRC_HTRANS_NONSEQ  2'h2
`define GTRC_HSIZE_WORD     3'h2

`endif

// [verilog/gtrc_pin_sync.v]
`timescale 1ns/1ps

// =====================================================================
// two-stage synchroniser with edge detection on the settled copy
module gtrc_pin_sync (
    // clock and reset
    input  wire MCLK,
    input  wire SYS_RST,
    // raw pin
    input  wire pin_in,
    // conditioned outputs
    output reg  level,
    output wire rise,
    output wire fall
);

    reg meta_reg;
    reg sync_reg;

    // first stage only feeds the second; edges come from later copies
    always @(posedge MCLK) begin
        if (SYS_RST) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            level    <= 1'b0;
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            level    <= sync_reg;
        end
    end

    assign rise = sync_reg & ~level;
    assign fall = ~sync_reg & level;

endmodule // gtrc_pin_sync

// [test/gtrc_chk_sva.sv]
`timescale 1ns/1ps
// =====================================================================
// port checks for the reload/capture timer
module gtrc_chk (
    // clock and reset
    input wire        MCLK,
    input wire        SYS_RST,
    // bus in
    input wire        HSEL,
    input wire [7:0]  HADDR,
    input wire [1:0]  HTRANS,
    input wire        HWRITE,
    input wire [31:0] HWDATA,
    input wire        HREADY,
    // bus out and event
    input wire [31:0] HRDATA,
    input wire        HREADYOUT,
    input wire        HRESP,
    input wire        TIMER_IRQ
);
    wire       tk = HSEL && HREADY && HTRANS[1];
    reg        wc_reg;
    reg  [5:0] ctl_reg;
    // shadow of control, since the mode is not visible at the ports
    always @(posedge MCLK) begin
        if (SYS_RST) begin
            wc_reg  <= 1'h0;
            ctl_reg <= 6'h00;
        end else begin
            wc_reg <= tk && HWRITE && HADDR == 8'h00;
            if (wc_reg) ctl_reg <= HWDATA[5:0];
        end
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    ready_always_a: assert property (HREADYOUT)
        else $error("hreadyout low");
    resp_okay_a: assert property (!HRESP)
        else $error("error response");
    reset_values_a: assert property ($fell(SYS_RST) |->
        HRDATA == 32'h0 && !TIMER_IRQ) else $error("bad reset outputs");
    rdata_hold_a: assert property (!$stable(HRDATA) && !$past(SYS_RST)
        |-> $past(tk && !HWRITE)) else $error("read data moved");
    unmapped_zero_a: assert property (tk && !HWRITE && HADDR > 8'h0C
        |=> HRDATA == 32'h0) else $error("hole read not zero");
    ctrl_readback_a: assert property (tk && !HWRITE && HADDR == 8'h00
        |=> HRDATA == {26'h0, $past(ctl_reg)}) else $error("ctrl readback");
    updown_quiet_a: assert property ($rose(TIMER_IRQ)
        |-> !$past(ctl_reg[2] && !ctl_reg[1])) else $error("irq in updown");
    flag_clear_a: assert property (tk && HWRITE && HADDR == 8'h04 ##1
        (HWDATA[0] && ctl_reg == 6'h00) |-> ##[1:2] !TIMER_IRQ)
        else $error("irq not cleared");
endmodule // gtrc_chk

bind gtrc_timer gtrc_chk u_chk (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .TIMER_IRQ(TIMER_IRQ));

// [test/gtrc_pin_src.sv]
`timescale 1ns/1ps
// =====================================================================
// trigger pin source: a push-pull level, changed just after the edge
module gtrc_pin_src (
    // clock and requested level
    input  wire MCLK,
    input  wire lvl,
    // pin
    output reg  pin = 1'h0
);
    // registered so the pin never moves on the sampling edge
    always @(posedge MCLK) begin
        pin <= lvl;
    end
endmodule // gtrc_pin_src

// [test/testbench.sv]
`timescale 1ns/1ps
`include "gtrc_regs.vh"
// =====================================================================
// bus-driven tests of the reload/capture timer
module testbench;
    reg          mclk = 1'h0;
    reg          rst = 1'h1;
    reg          hsel = 1'h0;
    reg  [7:0]   haddr = 8'h00;
    reg  [1:0]   htrans = 2'h0;
    reg          hwrite = 1'h0;
    reg  [31:0]  hwdata = 32'h0;
    reg          lvl = 1'h0;
    wire [31:0]  hrdata;
    wire         hrdy;
    wire         hresp;
    wire         pin;
    wire         irq;
    logic [31:0] v;
    logic [31:0] w;
    int          fail_count = 0;
    int          check_count = 0;
    int          cyc = 0;
    initial forever #2 mclk = ~mclk;
    gtrc_pin_src i_pin (.MCLK(mclk), .lvl(lvl), .pin(pin));
    gtrc_timer i_dut (.MCLK(mclk), .SYS_RST(rst), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(`GTRC_HSIZE_WORD), .HWDATA(hwdata), .HREADY(hrdy),
        .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp),
        .EXT_TRIGGER_PIN(pin), .TIMER_IRQ(irq));
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    // one single transfer; address held until hready, then data phase
    task automatic bus(input logic [7:0] a, input logic we,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge mclk);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= we;
        htrans <= `GTRC_HTRANS_NONSEQ;
        do @(posedge mclk); while (hrdy !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hrdy !== 1'h1);
        r = hrdata;
    endtask
    // a hang ends in the same report
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'h0;
        bus(`GTRC_ADDR_CTRL, 1'h0, 32'h0, v);
        chk("ctrl_rst", v, 32'h0);
        bus(8'h10, 1'h1, 32'hFFFF, v);
        bus(8'h10, 1'h0, 32'h0, v);
        chk("hole", v, 32'h0);
        // prescaled: reads 120 clocks apart see ten steps
        bus(`GTRC_ADDR_CTRL, 1'h1, 32'h01, v);
        bus(`GTRC_ADDR_COUNT, 1'h0, 32'h0, v);
        repeat (117) @(posedge mclk);
        bus(`GTRC_ADDR_COUNT, 1'h0, 32'h0, w);
        chk("rate", w - v, 32'hA);
        // up count wraps to the reload value and flags it
        bus(`GTRC_ADDR_CTRL, 1'h1, 32'h0, v);
        bus(`GTRC_ADDR_RELOAD, 1'h1, 32'hFFF0, v);
        bus(`GTRC_ADDR_COUNT, 1'h1, 32'hFFF0, v);
        bus(`GTRC_ADDR_CTRL, 1'h1, 32'h21, v);
        repeat (40) @(posedge mclk);
        chk("irq_up", {31'h0, irq}, 32'h1);
        bus(`GTRC_ADDR_COUNT, 1'h0, 32'h0, v);
        chk("up", {31'h0, v - 32'hFFF0 < 32'h10}, 32'h1);
        // a second read three clocks later must have moved on
        bus(`GTRC_ADDR_COUNT, 1'h0, 32'h0, w);
        chk("up_run", {31'h0, w != v}, 32'h1);
        // up/down with pin low: down, wraps to all ones, silent
        bus(`GTRC_ADDR_CTRL, 1'h1, 32'h0, v);
        bus(`GTRC_ADDR_STATUS, 1'h1, 32'h1, v);
        bus(`GTRC_ADDR_COUNT, 1'h1, 32'hFFF8, v);
        bus(`GTRC_ADDR_CTRL, 1'h1, 32'h25, v);
        repeat (40) @(posedge mclk);
        chk("irq_dn", {31'h0, irq}, 32'h0);
        bus(`GTRC_ADDR_STATUS, 1'h0, 32'h0, v);
        chk("dir_dn", v & 32'h6, 32'h2);
        bus(`GTRC_ADDR_COUNT, 1'h0, 32'h0, v);
        chk("dn", {31'h0, v >= 32'hFFF0 && v < 32'h10000}, 32'h1);
        lvl <= 1'h1;
        repeat (40) @(posedge mclk);
        bus(`GTRC_ADDR_STATUS, 1'h0, 32'h0, v);
        chk("dir_up", v & 32'h6, 32'h4);
        chk("irq_ud", {31'h0, irq}, 32'h0);
        // rising pin edge reloads an up count
        bus(`GTRC_ADDR_CTRL, 1'h1, 32'h0, v);
        lvl <= 1'h0;
        bus(`GTRC_ADDR_STATUS, 1'h1, 32'h1, v);
        bus(`GTRC_ADDR_RELOAD, 1'h1, 32'h1234, v);
        bus(`GTRC_ADDR_COUNT, 1'h1, 32'h8000, v);
        bus(`GTRC_ADDR_CTRL, 1'h1, 32'h39, v);
        lvl <= 1'h1;
        repeat (8) @(posedge mclk);
        bus(`GTRC_ADDR_COUNT, 1'h0, 32'h0, v);
        chk("pin_rl", {31'h0, v - 32'h1234 < 32'h1C}, 32'h1);
        chk("irq_rl", {31'h0, irq}, 32'h1);
        // capture mode: wrap to zero, then a rising edge captures
        bus(`GTRC_ADDR_CTRL, 1'h1, 32'h0, v);
        lvl <= 1'h0;
        bus(`GTRC_ADDR_STATUS, 1'h1, 32'h1, v);
        bus(`GTRC_ADDR_COUNT, 1'h1, 32'hFFF0, v);
        bus(`GTRC_ADDR_CTRL, 1'h1, 32'h3B, v);
        repeat (30) @(posedge mclk);
        chk("irq_ov", {31'h0, irq}, 32'h1);
        bus(`GTRC_ADDR_COUNT, 1'h0, 32'h0, v);
        chk("cap_wrap", {31'h0, v < 32'h40}, 32'h1);
        bus(`GTRC_ADDR_STATUS, 1'h1, 32'h1, v);
        repeat (3) @(posedge mclk);
        chk("irq_clr", {31'h0, irq}, 32'h0);
        lvl <= 1'h1;
        repeat (8) @(posedge mclk);
        chk("irq_cap", {31'h0, irq}, 32'h1);
        bus(`GTRC_ADDR_RELOAD, 1'h0, 32'h0, v);
        chk("cap", {31'h0, v > 32'h0 && v < 32'h80}, 32'h1);
        tally_and_finish;
    end
endmodule // testbench
